//--- src/smc_defs.svh
// Constant definitions for the step/direction motor controller
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH
`define SMC_CLK_HZ 64'd200000000
`define SMC_SEC_PER_MIN 64'd60
`define SMC_FULL_STEP_CODE 4'h8
`define SMC_MAX_RES_CODE 4'h8
`define SMC_CUR_MAX 4'hF
`define SMC_SPI_BITS 5'd20
`define SMC_SPI_DIV 8'd9
`define SMC_DIR_CW 1'b0
`define SMC_DIR_CCW 1'b1
`endif

//--- src/smc_pkg.sv
// Types for the step/direction motor controller
package smc_pkg;
  typedef struct packed {
    logic continuous;
    logic direction;
    logic [3:0] res_code;
    logic [15:0] speed_rpm;
    logic [15:0] steps_per_rev;
    logic [31:0] step_count;
    logic load;
  } smc_motion_t;
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } smc_spi_out_t;
  typedef enum logic [2:0] {
    SMC_SPI_IDLE = 3'b001,
    SMC_SPI_SHIFT = 3'b010,
    SMC_SPI_DONE = 3'b100
  } smc_spi_state_t;
endpackage : smc_pkg

//--- src/smc_top.sv
// Step/direction commutator and 20-bit serial configuration channel
//
// Operation
// - Current scale 0..15 accepted; 0 lowest current, 15 highest, passed on
// - Commutator drives direction output and step pulse train to driver
// - Step interval is a counted number of system clocks; sets speed
// - Continuous mode steps until the axis is disabled or the commutator is reset
// - Finite mode emits exactly the set steps, stops; driver stays enabled
// - Pulsing only in continuous mode or remaining count above zero
// - Decrement delay while nonzero; at zero toggle step and reload
// - Exchange 20-bit serial frames to write driver configuration
// - Capture status frame returned during each transfer for reading
// - Ready output high whenever a new word can be accepted
// - Direction bit 0 clockwise, 1 anticlockwise
// - Word written with start bit; transfer begins when bit set
// - All parameters arrive from the processor bus side
// - Wait = fclk*60*2^(res-8) / (rpm * full steps per revolution)
// - Resolution code 4 bits; 0 is 256 microsteps, 8 full step
// - Speed, direction, resolution change live; current only while stopped
`timescale 1ns/1ps
`default_nettype none
`include "smc_defs.svh"
module smc_top
  import smc_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic axis_enable_i,
  input wire smc_motion_t motion_i,
  input wire logic [3:0] current_scale_i,
  input wire logic [19:0] spi_word_i,
  input wire logic spi_start_i,
  input wire logic spi_miso_i,
  output logic step_pulse_out_o,
  output logic direction_o,
  output logic driver_enable_o,
  output logic running_o,
  output logic [31:0] remaining_step_count_o,
  output logic [3:0] current_scale_o,
  output smc_spi_out_t spi_o,
  output logic spi_ready_o,
  output logic [19:0] spi_status_o
);
  logic [31:0] delay_reg;
  logic [31:0] wait_next;
  logic [31:0] remaining_step_count;
  logic active;
  logic [63:0] num;
  logic [63:0] den;
  logic [3:0] res_lim;
  logic [4:0] shift_amt;

  // Wait count from speed and resolution; zero speed gives the longest wait
  always_comb begin
    res_lim = (motion_i.res_code > `SMC_MAX_RES_CODE) ? `SMC_MAX_RES_CODE :
      motion_i.res_code;
    shift_amt = {1'b0, `SMC_FULL_STEP_CODE - res_lim};
    num = `SMC_CLK_HZ * `SMC_SEC_PER_MIN;
    den = ({48'h0, motion_i.speed_rpm} * {48'h0, motion_i.steps_per_rev})
      << shift_amt;
    if (den == 64'h0) begin
      wait_next = 32'hFFFFFFFF;
    end else begin
      wait_next = 32'((num / den) > 64'h1 ? (num / den) - 64'h1 : 64'h0);
    end
  end

  assign active = axis_enable_i &&
    (motion_i.continuous || remaining_step_count != 32'h0);

  // Delay counter and step toggling
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      delay_reg <= 32'h0;
      step_pulse_out_o <= 1'b0;
    end else if (active) begin
      if (delay_reg == 32'h0) begin
        step_pulse_out_o <= ~step_pulse_out_o;
        delay_reg <= wait_next;
      end else begin
        delay_reg <= delay_reg - 32'h1;
      end
    end
  end

  // Finite step count: one decrement per complete pulse (falling edge)
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      remaining_step_count <= 32'h0;
    end else if (motion_i.load) begin
      remaining_step_count <= motion_i.step_count;
    end else if (active && !motion_i.continuous && delay_reg == 32'h0 &&
                 step_pulse_out_o) begin
      remaining_step_count <= remaining_step_count - 32'h1;
    end
  end

  // Direction and enable follow the axis settings live
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      direction_o <= `SMC_DIR_CW;
      driver_enable_o <= 1'b0;
      running_o <= 1'b0;
      remaining_step_count_o <= 32'h0;
    end else begin
      direction_o <= motion_i.direction;
      driver_enable_o <= axis_enable_i;
      running_o <= active;
      remaining_step_count_o <= remaining_step_count;
    end
  end

  // Current scale is taken only while the axis is not stepping
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      current_scale_o <= 4'h0;
    end else if (!active) begin
      current_scale_o <= current_scale_i;
    end
  end

  // Three-flop synchroniser; a level counts once the last two flops agree
  logic [2:0] miso_sync;
  logic miso_filt;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      miso_sync <= 3'h0;
      miso_filt <= 1'b0;
    end else begin
      miso_sync <= {miso_sync[1:0], spi_miso_i};
      if (miso_sync[2] == miso_sync[1]) begin
        miso_filt <= miso_sync[2];
      end
    end
  end

  smc_spi_state_t spi_state;
  logic [7:0] div_cnt;
  logic [4:0] bit_cnt;
  logic [19:0] tx_sr;
  logic [19:0] rx_sr;
  logic tick;
  logic miso_bit;
  assign tick = (div_cnt == 8'h0);
  assign miso_bit = miso_filt;

  // Half-period divider for the serial clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_cnt <= `SMC_SPI_DIV;
    end else if (spi_state != SMC_SPI_SHIFT || tick) begin
      div_cnt <= `SMC_SPI_DIV;
    end else begin
      div_cnt <= div_cnt - 8'h1;
    end
  end

  // Serial transfer: mode 3, MSB first, 20 bits
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      spi_state <= SMC_SPI_IDLE;
      spi_o <= '{sclk: 1'b1, mosi: 1'b0, cs_n: 1'b1};
      spi_ready_o <= 1'b1;
      spi_status_o <= 20'h0;
      tx_sr <= 20'h0;
      rx_sr <= 20'h0;
      bit_cnt <= 5'h0;
    end else begin
      case (spi_state)
        SMC_SPI_IDLE: begin
          if (spi_start_i) begin
            tx_sr <= {spi_word_i[18:0], 1'b0};
            spi_o.mosi <= spi_word_i[19];
            spi_o.cs_n <= 1'b0;
            spi_ready_o <= 1'b0;
            bit_cnt <= `SMC_SPI_BITS;
            spi_state <= SMC_SPI_SHIFT;
          end else begin
            spi_ready_o <= 1'b1;
          end
        end
        SMC_SPI_SHIFT: begin
          if (tick) begin
            if (spi_o.sclk) begin
              // Next bit goes out on the falling edge, first bit already set
              spi_o.sclk <= 1'b0;
              if (bit_cnt != `SMC_SPI_BITS) begin
                spi_o.mosi <= tx_sr[19];
                tx_sr <= {tx_sr[18:0], 1'b0};
              end
            end else begin
              spi_o.sclk <= 1'b1;
              rx_sr <= {rx_sr[18:0], miso_bit};
              bit_cnt <= bit_cnt - 5'h1;
              if (bit_cnt == 5'h1) begin
                spi_state <= SMC_SPI_DONE;
              end
            end
          end
        end
        SMC_SPI_DONE: begin
          spi_o.cs_n <= 1'b1;
          spi_status_o <= rx_sr;
          // Wait for the start bit to drop so one word is sent once
          if (!spi_start_i) begin
            spi_ready_o <= 1'b1;
            spi_state <= SMC_SPI_IDLE;
          end
        end
        default: begin
          spi_state <= SMC_SPI_IDLE;
        end
      endcase
    end
  end
endmodule : smc_top
`default_nettype wire

//--- tb/smc_drv_model.sv
// Serial status responder standing in for the motor driver chip
`timescale 1ns/1ps
`default_nettype none
module smc_drv_model #(parameter logic [19:0] STAT = 20'h5A3C6) (
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  output logic miso_o,
  output logic [19:0] rx_o
);
  logic [19:0] sh = 20'h0;
  logic lead = 1'b0;
  initial miso_o = 1'b0;
  always @(negedge cs_n_i) begin
    sh = STAT;
    lead = 1'b1;
    miso_o = STAT[19];
  end
  // Released line shows the inverse of its last bit
  always @(posedge cs_n_i) miso_o = ~miso_o;
  always @(negedge sclk_i) if (!cs_n_i) begin
    if (!lead) sh = sh << 1;
    miso_o = sh[19];
    lead = 1'b0;
  end
  always @(posedge sclk_i) if (!cs_n_i) rx_o = {rx_o[18:0], mosi_i};
endmodule : smc_drv_model
`default_nettype wire

//--- tb/smc_top_assertions.sv
// Port checker for the step/direction motor controller
`timescale 1ns/1ps
`default_nettype none
module smc_top_assertions import smc_pkg::*; (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic axis_enable_i,
  input wire smc_motion_t motion_i,
  input wire logic spi_start_i,
  input wire logic step_pulse_out_o,
  input wire logic direction_o,
  input wire logic driver_enable_o,
  input wire logic running_o,
  input wire logic [31:0] remaining_step_count_o,
  input wire logic [3:0] current_scale_o,
  input wire smc_spi_out_t spi_o,
  input wire logic spi_ready_o
);
  logic [4:0] rises;
  logic sclk_q;
  // Counts serial clock rises inside one frame
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rises <= 5'h0;
      sclk_q <= 1'b1;
    end else begin
      sclk_q <= spi_o.sclk;
      if (spi_o.cs_n) rises <= 5'h0;
      else if (spi_o.sclk && !sclk_q) rises <= rises + 5'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  AST_DIR: assert property ($past(reset_n_i) |->
    direction_o == $past(motion_i.direction)) else $error("direction lag");
  AST_ENA: assert property ($past(reset_n_i) |->
    driver_enable_o == $past(axis_enable_i)) else $error("enable lag");
  AST_HOLD: assert property (!axis_enable_i |=>
    $stable(step_pulse_out_o)) else $error("step moved while off");
  AST_CNT: assert property ($changed(remaining_step_count_o) &&
    !$past(motion_i.load, 2) |-> $past(step_pulse_out_o, 2) &&
    !$past(step_pulse_out_o) &&
    remaining_step_count_o == $past(remaining_step_count_o) - 32'h1)
    else $error("count step wrong");
  AST_SCALE: assert property (running_o |-> $stable(current_scale_o))
    else $error("scale changed while running");
  AST_TAKE: assert property (spi_ready_o && spi_start_i |=>
    !spi_ready_o && !spi_o.cs_n) else $error("start not taken");
  AST_BUSY: assert property (!spi_o.cs_n |-> !spi_ready_o)
    else $error("ready during frame");
  AST_LEN: assert property ($rose(spi_o.cs_n) |-> rises == 5'h14)
    else $error("frame length wrong");
  cover property ($fell(step_pulse_out_o));
  cover property ($rose(spi_o.cs_n));
  cover property (running_o ##1 !running_o);
endmodule : smc_top_assertions
`default_nettype wire

//--- tb/smc_top_test.sv
// Self-checking bench for the step/direction motor controller
`timescale 1ns/1ps
`default_nettype none
module smc_top_test import smc_pkg::*;;
  localparam logic [19:0] STAT = 20'h5A3C6;
  logic clk_i = 1'b0, reset_n_i = 1'b0, axis_enable_i = 1'b0;
  logic spi_start_i = 1'b0, spi_miso_i, step_pulse_out_o, direction_o;
  logic driver_enable_o, running_o, spi_ready_o, prev;
  smc_motion_t motion_i = '0;
  logic [3:0] current_scale_i = 4'h0, current_scale_o;
  logic [19:0] spi_word_i = 20'h0, spi_status_o, rx;
  logic [31:0] remaining_step_count_o;
  smc_spi_out_t spi_o;
  int bad_count = 0, checks_done = 0, cyc = 0, last = 0, gap = 0, tog = 0, n;
  // Rows: direction, scale, expected direction, expected scale
  logic [9:0] rows [4] = '{10'h000, 10'h2F7, 10'h0A5, 10'h3FF};
  smc_top uut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .axis_enable_i(axis_enable_i), .motion_i(motion_i),
    .current_scale_i(current_scale_i), .spi_word_i(spi_word_i),
    .spi_start_i(spi_start_i), .spi_miso_i(spi_miso_i),
    .step_pulse_out_o(step_pulse_out_o), .direction_o(direction_o),
    .driver_enable_o(driver_enable_o), .running_o(running_o),
    .remaining_step_count_o(remaining_step_count_o),
    .current_scale_o(current_scale_o), .spi_o(spi_o),
    .spi_ready_o(spi_ready_o), .spi_status_o(spi_status_o));
  smc_drv_model #(.STAT(STAT)) drv (.sclk_i(spi_o.sclk), .mosi_i(spi_o.mosi),
    .cs_n_i(spi_o.cs_n), .miso_o(spi_miso_i), .rx_o(rx));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, checks_done);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : complete_run
  task automatic spi_tx(input logic [19:0] w);
    spi_word_i = w;
    spi_start_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 spi_start_i = 1'b0;
    for (n = 0; n < 1000 && spi_ready_o !== 1'b1; n++) @(posedge clk_i);
    #1 chk(32'(n < 1000), 32'h1);
    chk(32'(rx), 32'(w));
    chk(32'(spi_status_o), 32'(STAT));
  endtask : spi_tx
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (step_pulse_out_o !== prev) begin
      gap = cyc - last;
      last = cyc;
      tog++;
    end
    prev = step_pulse_out_o;
    if (cyc > 5000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    chk(32'({spi_ready_o, spi_o, step_pulse_out_o}), 32'h1A);
    #1 reset_n_i = 1'b1;
    foreach (rows[i]) begin
      {motion_i.direction, current_scale_i} = rows[i][9:5];
      repeat (2) @(posedge clk_i);
      #1 chk(32'({direction_o, current_scale_o}), 32'(rows[i][4:0]));
    end
    motion_i.speed_rpm = 16'hEA60;
    motion_i.steps_per_rev = 16'hC350;
    motion_i.res_code = 4'h8;
    motion_i.step_count = 32'h2;
    motion_i.load = 1'b1;
    @(posedge clk_i) #1 motion_i.load = 1'b0;
    axis_enable_i = 1'b1;
    tog = 0;
    repeat (40) @(posedge clk_i);
    #1 chk(tog, 4);
    chk(gap, 32'(64'h2CB417800 / 64'hB2D05E00));
    chk({remaining_step_count_o[30:0], driver_enable_o}, 32'h1);
    motion_i.continuous = 1'b1;
    motion_i.res_code = 4'h7;
    current_scale_i = 4'h3;
    repeat (40) @(posedge clk_i);
    #1 chk(gap, 32'(64'h2CB417800 / 64'h165A0BC00));
    chk(32'(tog > 20), 32'h1);
    chk(32'(running_o), 32'h1);
    chk(32'(current_scale_o), 32'hF);
    axis_enable_i = 1'b0;
    motion_i.continuous = 1'b0;
    motion_i.step_count = 32'h0;
    motion_i.load = 1'b1;
    @(posedge clk_i) #1 motion_i.load = 1'b0;
    n = tog;
    repeat (20) @(posedge clk_i);
    #1 chk(tog, n);
    chk(32'(current_scale_o), 32'h3);
    chk(32'(running_o), 32'h0);
    spi_tx(20'hC3A5F);
    spi_tx(20'h3C5A0);
    // Reset in mid-run stops a continuous axis
    axis_enable_i = 1'b1;
    motion_i.continuous = 1'b1;
    repeat (10) @(posedge clk_i);
    #1 reset_n_i = 1'b0;
    @(posedge clk_i) #1 chk(32'({step_pulse_out_o, running_o}), 32'h0);
    reset_n_i = 1'b1;
    axis_enable_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 chk(32'({running_o, driver_enable_o}), 32'h0);
    complete_run();
  end
endmodule : smc_top_test
bind smc_top smc_top_assertions sva (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .axis_enable_i(axis_enable_i), .motion_i(motion_i),
  .spi_start_i(spi_start_i), .step_pulse_out_o(step_pulse_out_o),
  .direction_o(direction_o), .driver_enable_o(driver_enable_o),
  .running_o(running_o), .remaining_step_count_o(remaining_step_count_o),
  .current_scale_o(current_scale_o), .spi_o(spi_o),
  .spi_ready_o(spi_ready_o));
`default_nettype wire
